/* File: design/dtss_pkg.sv */
/*
  Shared types and constants for the transfer and search sequencer.
  Assumes an 8-bit data path and a 16-line address bus.
*/
package dtss_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;

  // Bus tenure modes
  typedef enum logic [1:0] {
    MODE_BYTE = 2'h0,
    MODE_DEMAND = 2'h1,
    MODE_BLOCK = 2'h2
  } dtss_mode_t;

  // Action taken on a byte match
  typedef enum logic [1:0] {
    MATCH_CONTINUE = 2'h0,
    MATCH_STOP = 2'h1,
    MATCH_INTERRUPT = 2'h2
  } dtss_match_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_WAIT_RDY = 4'h1,
    ST_REQ = 4'h2,
    ST_RD1 = 4'h3,
    ST_RD2 = 4'h4,
    ST_WR1 = 4'h5,
    ST_WR2 = 4'h6,
    ST_CHECK = 4'h7,
    ST_PAUSE = 4'h8,
    ST_RELEASE = 4'h9
  } dtss_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] start;
    logic fixed;
    logic count_up;
    logic is_io;
  } dtss_port_cfg_t;

  // Bus cycle strobes, all active high
  typedef struct packed {
    logic rd;
    logic wr;
    logic mreq;
    logic iorq;
  } dtss_strobe_t;

  localparam dtss_strobe_t STROBE_IDLE = 4'h0;

  // Synchroniser lanes and their idle levels
  localparam int SY_RDY = 0;
  localparam int SY_ACK_N = 1;
  localparam int SY_REQ_N = 2;
  localparam int SY_LANES = 3;
  localparam logic [SY_LANES-1:0] SYNC_RESET = 3'h6;

  localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 16'h0001;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

endpackage

/* File: design/dtss_addr_port.sv */
/*
  Address counter of one port: loads the start address, then holds it
  or steps it by one up or down.
  Assumes load and step are single-cycle strobes from the sequencer.
*/
`timescale 1ns/1ps
module dtss_addr_port (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Configuration and strobes
  input wire dtss_pkg::dtss_port_cfg_t cfg,
  input wire logic load,
  input wire logic step,
  // Current and next address
  output logic [dtss_pkg::ADDR_W-1:0] addr,
  output logic [dtss_pkg::ADDR_W-1:0] addr_next
);

  always_comb begin
    addr_next = addr;
    if (load) begin
      addr_next = cfg.start;
    end else if (step && !cfg.fixed) begin
      if (cfg.count_up) begin
        addr_next = addr + dtss_pkg::ADDR_STEP;
      end else begin
        addr_next = addr - dtss_pkg::ADDR_STEP;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      addr <= dtss_pkg::ADDR_RESET;
    end else begin
      addr <= addr_next;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  chk_fixed_holds: assert property (
    (step && !load && cfg.fixed) |=> addr == $past(addr))
    else $error("fixed port address moved");

  chk_count_step: assert property (
    (step && !load && !cfg.fixed) |=>
      addr == (cfg.count_up ? $past(addr) + dtss_pkg::ADDR_STEP
                            : $past(addr) - dtss_pkg::ADDR_STEP))
    else $error("counting port stepped wrongly");

endmodule

/* File: design/dtss_sequencer.sv */
/*
  Sequencing core of an 8-bit bus-mastering transfer and search engine:
  tenure modes, per-byte read/write/compare order, end of block, stop on
  match, and two-port address generation.
  Assumes a host that grants the bus on request, ports with ready lines,
  and a testbench that resolves the tristate and open-drain pins.
*/
// Overview of operation
// - One of byte, demand or block mode
// - Byte mode releases bus after every byte
// - Enable, ready active, then request; host grants
// - Byte mode releases so host runs a cycle
// - Demand mode bursts until ready, end, stop-match
// - Demand: ready lost, finish byte, release bus
// - Demand: wait ready active, re-request, resume
// - Block mode holds bus until end or stop
// - Block: ready lost, idle holding the bus
// - Byte once read always runs to completion
// - Step source, read, step destination, write
// - Search compares byte; no match counts on
// - Match sets flag; continue, stop or interrupt
// - Count equals length: end flag, terminate
// - Byte completes only once next byte read
// - Source or destination address on shared bus
// - Ports: direction, memory/io, fixed/counting
// - Counting port steps up or down from start
// - Read and write cycles last two clocks
// - Read byte held and driven during write
// - Sixteen-line tristate address bus output
`timescale 1ns/1ps
module dtss_sequencer #(
  parameter int CNT_W = dtss_pkg::CNT_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Commands
  input wire logic enable_cmd,
  input wire logic disable_cmd,
  input wire logic status_clr,
  // Configuration
  input wire dtss_pkg::dtss_mode_t mode,
  input wire dtss_pkg::dtss_port_cfg_t port_a_cfg,
  input wire dtss_pkg::dtss_port_cfg_t port_b_cfg,
  input wire logic a_is_source,
  input wire logic transfer_en,
  input wire logic search_en,
  input wire logic [dtss_pkg::DATA_W-1:0] match_byte,
  input wire logic [dtss_pkg::DATA_W-1:0] match_mask,
  input wire dtss_pkg::dtss_match_t match_action,
  input wire logic [CNT_W-1:0] block_len,
  // Status
  output logic active,
  output logic match_flag,
  output logic eob_flag,
  output logic int_request,
  output logic ready_seen,
  output logic [CNT_W-1:0] byte_count,
  // Bus request pin (open drain, low active) and grant
  input wire logic bus_request_line_in,
  output logic bus_request_line_out,
  output logic bus_request_line_oe,
  input wire logic bus_ack_n,
  // Port ready
  input wire logic port_ready,
  // Address bus
  output logic [dtss_pkg::ADDR_W-1:0] system_address_lines_out,
  output logic system_address_lines_oe,
  // Data bus
  input wire logic [dtss_pkg::DATA_W-1:0] data_in,
  output logic [dtss_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  // Cycle strobes
  output dtss_pkg::dtss_strobe_t strobe_out,
  output logic strobe_oe
);

  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt
    $error("CNT_W must lie between 2 and 32");
  end

  // Pin synchronisers: a change counts once stages two and three agree
  logic [dtss_pkg::SY_LANES-1:0] sy1, sy2, sy3, syf, next_syf;

  always_comb begin
    for (int i = 0; i < dtss_pkg::SY_LANES; i++) begin
      next_syf[i] = (sy2[i] == sy3[i]) ? sy3[i] : syf[i];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sy1 <= dtss_pkg::SYNC_RESET;
      sy2 <= dtss_pkg::SYNC_RESET;
      sy3 <= dtss_pkg::SYNC_RESET;
      syf <= dtss_pkg::SYNC_RESET;
    end else begin
      sy1 <= {bus_request_line_in, bus_ack_n, port_ready};
      sy2 <= sy1;
      sy3 <= sy2;
      syf <= next_syf;
    end
  end

  logic rdy_f, granted, other_req;
  assign rdy_f = syf[dtss_pkg::SY_RDY];
  assign granted = !syf[dtss_pkg::SY_ACK_N];
  assign other_req = !syf[dtss_pkg::SY_REQ_N];

  // Sequencer state
  dtss_pkg::dtss_state_t state, next_state;
  logic next_active, first, next_first, pending, next_pending;
  logic [CNT_W-1:0] byte_cnt, next_cnt;
  logic [dtss_pkg::DATA_W-1:0] rd_buf, next_buf;
  logic next_match, next_eob, next_int;
  logic load, src_step, dst_step, hit, eob, stop;

  assign hit = search_en
    && (((rd_buf ^ match_byte) & ~match_mask) == dtss_pkg::DATA_RESET);
  assign eob = (byte_cnt == block_len);
  assign stop = eob || (hit && match_action != dtss_pkg::MATCH_CONTINUE);

  always_comb begin
    next_state = state;
    next_active = active;
    next_first = first;
    next_pending = pending;
    next_cnt = byte_cnt;
    next_buf = rd_buf;
    load = 1'b0;
    case (state)
      dtss_pkg::ST_IDLE: begin
        if (enable_cmd) begin
          load = 1'b1;
          next_active = 1'b1;
          next_first = 1'b1;
          next_pending = 1'b0;
          next_cnt = '0;
          next_state = dtss_pkg::ST_WAIT_RDY;
        end
      end
      dtss_pkg::ST_WAIT_RDY: begin
        if (disable_cmd) begin
          next_active = 1'b0;
          next_state = dtss_pkg::ST_IDLE;
        end else if (rdy_f && !other_req) begin
          next_state = dtss_pkg::ST_REQ;
        end
      end
      dtss_pkg::ST_REQ: begin
        if (granted) begin
          next_state = dtss_pkg::ST_RD1;
        end
      end
      dtss_pkg::ST_RD1: begin
        next_state = dtss_pkg::ST_RD2;
      end
      dtss_pkg::ST_RD2: begin
        next_buf = data_in;
        if (pending) begin
          next_cnt = byte_cnt + CNT_W'(1);
          next_pending = 1'b0;
        end
        next_state = transfer_en ? dtss_pkg::ST_WR1 : dtss_pkg::ST_CHECK;
      end
      dtss_pkg::ST_WR1: begin
        next_state = dtss_pkg::ST_WR2;
      end
      dtss_pkg::ST_WR2: begin
        next_state = dtss_pkg::ST_CHECK;
      end
      dtss_pkg::ST_CHECK: begin
        next_first = 1'b0;
        next_pending = !eob;
        if (stop) begin
          next_active = 1'b0;
          next_state = dtss_pkg::ST_RELEASE;
        end else begin
          case (mode)
            dtss_pkg::MODE_BYTE: begin
              next_state = dtss_pkg::ST_RELEASE;
            end
            dtss_pkg::MODE_DEMAND: begin
              next_state = rdy_f ? dtss_pkg::ST_RD1
                                 : dtss_pkg::ST_RELEASE;
            end
            default: begin
              next_state = rdy_f ? dtss_pkg::ST_RD1
                                 : dtss_pkg::ST_PAUSE;
            end
          endcase
        end
      end
      dtss_pkg::ST_PAUSE: begin
        if (rdy_f) begin
          next_state = dtss_pkg::ST_RD1;
        end
      end
      dtss_pkg::ST_RELEASE: begin
        if (!granted) begin
          next_state = active ? dtss_pkg::ST_WAIT_RDY : dtss_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = dtss_pkg::ST_IDLE;
      end
    endcase
  end

  // Sticky status, a new event wins over a clear in the same cycle
  always_comb begin
    next_match = status_clr ? 1'b0 : match_flag;
    next_eob = status_clr ? 1'b0 : eob_flag;
    next_int = status_clr ? 1'b0 : int_request;
    if (state == dtss_pkg::ST_CHECK) begin
      if (hit) begin
        next_match = 1'b1;
      end
      if (hit && match_action == dtss_pkg::MATCH_INTERRUPT) begin
        next_int = 1'b1;
      end
      if (eob) begin
        next_eob = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state <= dtss_pkg::ST_IDLE;
      active <= 1'b0;
      first <= 1'b1;
      pending <= 1'b0;
      byte_cnt <= '0;
      rd_buf <= dtss_pkg::DATA_RESET;
      match_flag <= 1'b0;
      eob_flag <= 1'b0;
      int_request <= 1'b0;
    end else begin
      state <= next_state;
      active <= next_active;
      first <= next_first;
      pending <= next_pending;
      byte_cnt <= next_cnt;
      rd_buf <= next_buf;
      match_flag <= next_match;
      eob_flag <= next_eob;
      int_request <= next_int;
    end
  end

  // Address generation: the first byte uses the start addresses as loaded
  logic [dtss_pkg::ADDR_W-1:0] a_next, b_next, src_next, dst_next;
  logic src_io, dst_io;

  assign src_step = (next_state == dtss_pkg::ST_RD1)
    && (state != dtss_pkg::ST_RD1) && !next_first;
  assign dst_step = (next_state == dtss_pkg::ST_WR1) && !first;
  assign src_next = a_is_source ? a_next : b_next;
  assign dst_next = a_is_source ? b_next : a_next;
  assign src_io = a_is_source ? port_a_cfg.is_io : port_b_cfg.is_io;
  assign dst_io = a_is_source ? port_b_cfg.is_io : port_a_cfg.is_io;

  dtss_addr_port u_port_a (
    .mclk(mclk),
    .rstn(rstn),
    .cfg(port_a_cfg),
    .load(load),
    .step(a_is_source ? src_step : dst_step),
    .addr(),
    .addr_next(a_next)
  );

  dtss_addr_port u_port_b (
    .mclk(mclk),
    .rstn(rstn),
    .cfg(port_b_cfg),
    .load(load),
    .step(a_is_source ? dst_step : src_step),
    .addr(),
    .addr_next(b_next)
  );

  // Pin outputs, registered from the coming state
  logic rd_ph, wr_ph, own_bus;
  dtss_pkg::dtss_strobe_t next_strobe;
  logic [dtss_pkg::ADDR_W-1:0] next_addr_out;
  logic [dtss_pkg::DATA_W-1:0] next_data_out;

  always_comb begin
    rd_ph = (next_state == dtss_pkg::ST_RD1)
      || (next_state == dtss_pkg::ST_RD2);
    wr_ph = (next_state == dtss_pkg::ST_WR1)
      || (next_state == dtss_pkg::ST_WR2);
    own_bus = rd_ph || wr_ph || (next_state == dtss_pkg::ST_CHECK)
      || (next_state == dtss_pkg::ST_PAUSE);
    next_addr_out = wr_ph ? dst_next : src_next;
    next_data_out = (state == dtss_pkg::ST_RD2) ? data_in : rd_buf;
    next_strobe.rd = rd_ph;
    next_strobe.wr = wr_ph;
    next_strobe.mreq = (rd_ph && !src_io) || (wr_ph && !dst_io);
    next_strobe.iorq = (rd_ph && src_io) || (wr_ph && dst_io);
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      bus_request_line_oe <= 1'b0;
      system_address_lines_out <= dtss_pkg::ADDR_RESET;
      system_address_lines_oe <= 1'b0;
      data_out <= dtss_pkg::DATA_RESET;
      data_oe <= 1'b0;
      strobe_out <= dtss_pkg::STROBE_IDLE;
      strobe_oe <= 1'b0;
    end else begin
      bus_request_line_oe <= own_bus || (next_state == dtss_pkg::ST_REQ);
      system_address_lines_out <= next_addr_out;
      system_address_lines_oe <= own_bus;
      data_out <= next_data_out;
      data_oe <= wr_ph;
      strobe_out <= next_strobe;
      strobe_oe <= own_bus;
    end
  end

  assign bus_request_line_out = 1'b0;
  assign ready_seen = rdy_f;
  assign byte_count = byte_cnt;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence seq_read;
    state == dtss_pkg::ST_RD1 ##1 state == dtss_pkg::ST_RD2;
  endsequence

  sequence seq_write;
    state == dtss_pkg::ST_WR1 ##1 state == dtss_pkg::ST_WR2
      ##1 state == dtss_pkg::ST_CHECK;
  endsequence

  chk_read_completes: assert property (
    state == dtss_pkg::ST_RD1 |-> seq_read
      ##1 (state == dtss_pkg::ST_WR1 || state == dtss_pkg::ST_CHECK))
    else $error("read phase did not run through");

  chk_write_completes: assert property (
    state == dtss_pkg::ST_WR1 |-> seq_write)
    else $error("write phase did not run through");

  chk_read_width: assert property (
    $rose(strobe_out.rd) |-> strobe_out.rd[*2] ##1 !strobe_out.rd)
    else $error("read strobe not two clocks");

  chk_write_data: assert property (
    strobe_out.wr |-> data_oe && data_out == rd_buf)
    else $error("write data not the read byte");

  chk_request_ready: assert property (
    $rose(bus_request_line_oe) |-> $past(rdy_f))
    else $error("bus requested without ready");

  chk_byte_release: assert property (
    (state == dtss_pkg::ST_CHECK && mode == dtss_pkg::MODE_BYTE)
      |=> !bus_request_line_oe && state == dtss_pkg::ST_RELEASE)
    else $error("byte mode kept the bus");

  chk_demand_release: assert property (
    (state == dtss_pkg::ST_CHECK && mode == dtss_pkg::MODE_DEMAND
      && !rdy_f) |=> state == dtss_pkg::ST_RELEASE)
    else $error("demand mode kept bus without ready");

  chk_wait_ready: assert property (
    (state == dtss_pkg::ST_WAIT_RDY && !rdy_f)
      |=> state != dtss_pkg::ST_REQ)
    else $error("bus requested while not ready");

  chk_block_hold: assert property (
    state == dtss_pkg::ST_PAUSE |-> bus_request_line_oe
      && system_address_lines_oe)
    else $error("block pause dropped the bus");

  chk_eob_stop: assert property (
    (state == dtss_pkg::ST_CHECK && eob)
      |=> eob_flag && !active && state == dtss_pkg::ST_RELEASE)
    else $error("end of block not handled");

  chk_match_flag: assert property (
    (state == dtss_pkg::ST_CHECK && hit) |=> match_flag)
    else $error("match flag not set");

  chk_count_commit: assert property (
    (state == dtss_pkg::ST_RD2 && pending)
      |=> byte_cnt == CNT_W'($past(byte_cnt) + CNT_W'(1)) && !pending)
    else $error("byte count not committed on next read");

endmodule

/* File: verif/dtss_host_model.sv */
/*
  Host and port model for the transfer and search sequencer: grants the
  bus, serves reads from an address-derived pattern and logs writes.
  Assumes the engine drives strobes and addresses from mclk registers.
*/
`timescale 1ns/1ps
module dtss_host_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Log clear and grant lag in cycles
  input wire logic clr,
  input wire logic [3:0] lag,
  // Engine pins
  input wire logic req_oe,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic data_oe,
  input wire dtss_pkg::dtss_strobe_t strobe,
  input wire logic strobe_oe,
  // Grant and read data
  output logic bus_ack_n,
  output logic [7:0] rdata
);
  logic [15:0] wr_addr [0:15];
  logic [7:0] wr_data [0:15];
  logic wr_io [0:15];
  int wr_n, rd_n, rel_n, min_rd, run, hold;
  logic wr_d, rd_d, req_d;
  wire logic rd = strobe_oe & strobe.rd;
  wire logic wr = strobe_oe & strobe.wr;

  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction

  initial begin
    rdata = 8'hA5;
  end

  always @(posedge mclk) begin
    // Released data lines toggle so a stale byte never looks valid
    rdata <= rd ? pat(addr) : ~rdata;
    wr_d <= wr;
    rd_d <= rd;
    req_d <= req_oe;
    if (!rstn || !req_oe) begin
      bus_ack_n <= 1'b1;
      hold <= lag;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end else begin
      bus_ack_n <= 1'b0;
    end
    if (clr) begin
      wr_n <= 0;
      rd_n <= 0;
      rel_n <= 0;
      min_rd <= 99;
    end else begin
      if (wr && !wr_d && wr_n < 16) begin
        wr_addr[wr_n] <= addr;
        wr_data[wr_n] <= data_oe ? wdata : ~wdata;
        wr_io[wr_n] <= strobe.iorq;
        wr_n <= wr_n + 1;
      end
      if (rd && !rd_d) begin
        rd_n <= rd_n + 1;
        run <= 1;
      end else if (rd) begin
        run <= run + 1;
      end
      if (!rd && rd_d && run < min_rd) min_rd <= run;
      if (req_d && !req_oe) rel_n <= rel_n + 1;
    end
  end
endmodule

/* File: verif/tb_dtss_sequencer.sv */
/*
  Self-checking bench for the transfer and search sequencer.
  Assumes the host model above and a pulled-up request wire.
*/
`timescale 1ns/1ps
module tb_dtss_sequencer;
  logic mclk = 0, rstn = 0, en = 0, mclr = 0, sclr = 0, rdy = 1;
  logic a_src = 1, xfer = 1, srch = 0;
  dtss_pkg::dtss_mode_t mode = dtss_pkg::MODE_BYTE;
  dtss_pkg::dtss_port_cfg_t pa = '0, pb = '0;
  dtss_pkg::dtss_match_t act = dtss_pkg::MATCH_CONTINUE;
  dtss_pkg::dtss_strobe_t stb;
  logic [7:0] mb = 8'h00, mm = 8'h00, din, dout;
  logic [15:0] blen = 16'h0002, cnt, addr;
  logic [3:0] lag = 4'h3;
  logic act_o, mf, ef, irq, rs, req_oe, req_o, ack_n, a_oe, d_oe, s_oe;
  int errors = 0, compares = 0;
  wire logic req_in = ~req_oe;

  dtss_sequencer u_dut (.mclk(mclk), .rstn(rstn), .enable_cmd(en),
    .disable_cmd(1'b0), .status_clr(sclr), .mode(mode), .port_a_cfg(pa),
    .port_b_cfg(pb), .a_is_source(a_src), .transfer_en(xfer),
    .search_en(srch), .match_byte(mb), .match_mask(mm),
    .match_action(act), .block_len(blen), .active(act_o),
    .match_flag(mf), .eob_flag(ef), .int_request(irq), .ready_seen(rs),
    .byte_count(cnt), .bus_request_line_in(req_in),
    .bus_request_line_out(req_o), .bus_request_line_oe(req_oe),
    .bus_ack_n(ack_n), .port_ready(rdy), .system_address_lines_out(addr),
    .system_address_lines_oe(a_oe), .data_in(din), .data_out(dout),
    .data_oe(d_oe), .strobe_out(stb), .strobe_oe(s_oe));

  dtss_host_model u_host (.mclk(mclk), .rstn(rstn), .clr(mclr),
    .lag(lag), .req_oe(req_oe), .addr(addr), .wdata(dout),
    .data_oe(d_oe), .strobe(stb), .strobe_oe(s_oe), .bus_ack_n(ack_n),
    .rdata(din));

  initial begin
    forever #20 mclk = ~mclk;
  end

  task automatic final_report;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Enable one block and wait, bounded, until the engine stops
  task automatic run;
    int n;
    @(negedge mclk);
    mclr = 1;
    @(negedge mclk);
    mclr = 0;
    sclr = 1;
    en = 1;
    @(negedge mclk);
    sclr = 0;
    en = 0;
    n = 0;
    while (act_o !== 1'b0 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 2000) begin
      errors++;
      final_report();
    end
    repeat (16) @(negedge mclk);
  endtask

  // Let run clear the write log first, then drop ready after one write
  task automatic drop_ready;
    int n;
    repeat (2) @(negedge mclk);
    n = 0;
    while (u_host.wr_n < 1 && n < 500) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 500) begin
      errors++;
      final_report();
    end
    rdy = 0;
    repeat (20) @(negedge mclk);
    check(rs, 1'b0);
    check(req_o, 1'b0);
    if (mode == dtss_pkg::MODE_BLOCK) begin
      check(req_oe, 1'b1);
      check(a_oe, 1'b1);
      check(stb, dtss_pkg::STROBE_IDLE);
    end else begin
      check(req_oe, 1'b0);
      check(a_oe, 1'b0);
    end
    rdy = 1;
  endtask

  task automatic chk_writes(input int n, input logic [15:0] s, ss, d, ds,
                            input logic io);
    check(u_host.wr_n, n);
    check(u_host.min_rd, 2);
    for (int i = 0; i < n; i++) begin
      check(u_host.wr_addr[i], d);
      check(u_host.wr_data[i], u_host.pat(s));
      check(u_host.wr_io[i], io);
      s = s + ss;
      d = d + ds;
    end
    check(ef, 1'b1);
    check(cnt, blen);
  endtask

  task automatic t_byte;
    mode = dtss_pkg::MODE_BYTE;
    pa = {16'h1000, 1'b0, 1'b1, 1'b0};
    pb = {16'h2040, 1'b0, 1'b0, 1'b1};
    blen = 16'h0002;
    run();
    chk_writes(3, 16'h1000, 16'h0001, 16'h2040, 16'hFFFF, 1'b1);
    check(u_host.rel_n, 3);
  endtask

  task automatic t_demand;
    mode = dtss_pkg::MODE_DEMAND;
    a_src = 0;
    lag = 4'h0;
    pa = {16'h4000, 1'b0, 1'b1, 1'b0};
    pb = {16'h3000, 1'b1, 1'b0, 1'b1};
    blen = 16'h0003;
    fork
      run();
      drop_ready();
    join
    chk_writes(4, 16'h3000, 16'h0000, 16'h4000, 16'h0001, 1'b0);
    check(u_host.rel_n, 2);
  endtask

  task automatic t_block;
    mode = dtss_pkg::MODE_BLOCK;
    a_src = 1;
    lag = 4'h5;
    pa = {16'h10FE, 1'b0, 1'b1, 1'b0};
    pb = {16'h2000, 1'b0, 1'b0, 1'b0};
    fork
      run();
      drop_ready();
    join
    chk_writes(4, 16'h10FE, 16'h0001, 16'h2000, 16'hFFFF, 1'b0);
    check(u_host.rel_n, 1);
  endtask

  task automatic t_search;
    dtss_pkg::dtss_match_t at [5] = '{dtss_pkg::MATCH_CONTINUE,
      dtss_pkg::MATCH_STOP, dtss_pkg::MATCH_INTERRUPT,
      dtss_pkg::MATCH_STOP, dtss_pkg::MATCH_CONTINUE};
    logic [7:0] mbt [5] = '{8'h2C, 8'h2C, 8'h2C, 8'h2D, 8'h00};
    logic [7:0] mmt [5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
    int rdt [5] = '{5, 3, 3, 3, 5};
    xfer = 0;
    srch = 1;
    blen = 16'h0004;
    pa = {16'h1200, 1'b0, 1'b1, 1'b0};
    for (int k = 0; k < 5; k++) begin
      act = at[k];
      mb = mbt[k];
      mm = mmt[k];
      run();
      check(u_host.rd_n, rdt[k]);
      check(u_host.wr_n, 0);
      check(mf, k != 4);
      check(ef, rdt[k] == 5);
      check(irq, k == 2);
    end
  endtask

  initial begin
    repeat (6) @(negedge mclk);
    rstn = 1;
    t_byte();
    t_demand();
    t_block();
    t_search();
    final_report();
  end
endmodule
